//--- option_dispatch_consts.svh
/*
 Constants for the option microcode dispatch block: micro addresses,
 branch codes, opcode decode values, APB offsets and reset values.
 Assumes it is included by bare name, after the type package.
*/
`ifndef OPTION_DISPATCH_CONSTS_SVH
`define OPTION_DISPATCH_CONSTS_SVH

// Micro addresses (octal 100, 500, 640, 17, 7)
`define UADDR_BASE_DISPATCH 10'h040
`define UADDR_OPTION_ENTRY 10'h140
`define UADDR_VECTOR_FORM 10'h1a0
`define UADDR_SERVICE_RETURN 10'h00f
`define UADDR_ALT_TRAP 10'h007
// Trap vector 10 octal
`define TRAP_VECTOR_RSVD 16'h0008
// Option branch codes 17 and 16
`define BR_CODE_DEST_MODE 6'h0f
`define BR_CODE_OPCODE 6'h0e
`define BR_CODE_NONE 6'h00
// Opcode decode on instruction bits 15:9
`define OPC_ARITH_SHIFT_WORD 7'h3a
`define OPC_ARITH_SHIFT_COMB 7'h3b
`define OPC_OWN_LOW 7'h38
`define OPC_OWN_HIGH 7'h3b
// Floating group on instruction bits 15:5
`define OPC_FLOAT_GROUP 11'h3d4
// APB byte offsets
`define APB_OFF_CTRL 12'h000
`define APB_OFF_STATUS 12'h004
`define APB_OFF_RESULT 12'h008
`define APB_OFF_COUNT 12'h00c
// Reset values
`define CTRL_RESET 32'h0000_0001
// Words between the opcode test and the destination path exit
`define DEST_TEST_LEAD 3'h2

`endif

//--- option_dispatch_pkg.sv
/*
 Types for the option microcode dispatch block.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package option_dispatch_pkg;

    typedef enum logic [8:0] {
        ST_IDLE   = 9'h001,
        ST_ENTRY  = 9'h002,
        ST_SECOND = 9'h004,
        ST_DEST   = 9'h008,
        ST_SHIFT  = 9'h010,
        ST_STATUS = 9'h020,
        ST_CLEAN  = 9'h040,
        ST_VECTOR = 9'h080,
        ST_TRAPST = 9'h100
    } flow_state_t;

    // 81-bit option microword: upper 24 bits feed the option register
    typedef struct packed {
        logic [23:0] opt_hi;
        logic [5:0] branch;
        logic [9:0] next_addr;
        logic [40:0] ctl;
    } microword_t;

    // Condition bits handed back to the processor status
    typedef struct packed {
        logic n;
        logic z;
        logic v;
        logic c;
    } cond_t;

    typedef struct packed {
        logic [15:0] high;
        logic [15:0] low;
        cond_t cc;
    } shift_res_t;

endpackage

//--- option_microcode_dispatch.sv
/*
 Option microcode dispatch: hands microprogram control between the
 processor's basic control store and the option store, re-decodes the
 instruction, walks the destination paths, performs both arithmetic
 shifts, and exits through the service return or the alternate trap.
 Assumes all processor strobes are synchronous to sys_clk_i and that
 the processor keeps its own side of the hand-off.
*/
// The APB interface to the registers and the address map were left to the implementer.
`timescale 1ns/100ps
`include "option_dispatch_consts.svh"

module option_microcode_dispatch
    import option_dispatch_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_i,
    // APB slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // Processor dispatch hand-off
    input wire logic dispatch_test_i,
    input wire logic timing_pulse_i,
    input wire logic reserved_instr_flag_i,
    input wire logic store_select_bit_i,
    input wire logic [15:0] instr_i,
    output logic store_select_clk_o,
    output logic store_select_d_o,
    output logic option_store_en_o,
    output logic base_store_dis_o,
    output logic trap_flag_clr_o,
    // Microword buses
    output logic [56:0] micro_word_o,
    output logic [23:0] option_word_o,
    output logic [9:0] micro_pointer_o,
    output logic [5:0] option_branch_code_o,
    // Datapath operands
    input wire logic [15:0] bus_data_i,
    input wire logic [15:0] dest_reg_i,
    input wire logic [15:0] source_field_reg_i,
    input wire logic [15:0] odd_partner_reg_i,
    input wire logic [15:0] special_trap_marker_i,
    // Datapath results
    output logic [15:0] destination_field_reg_o,
    output logic [15:0] holding_reg_o,
    output logic [15:0] b_reg_o,
    output logic [15:0] source_field_wr_o,
    output logic [15:0] odd_partner_wr_o,
    output logic odd_partner_we_o,
    output logic [15:0] vector_scratch_o,
    output logic [15:0] trap_vector_o,
    output logic [3:0] proc_status_cc_o
);

    flow_state_t state_ff, nxt_state;
    logic option_enable_ff;
    logic option_select_copy_ff;
    logic [2:0] dest_cnt_ff;
    logic [2:0] dest_mode_ff;
    logic is_own_ff, is_float_ff, is_comb_ff;
    cond_t cc_ff;
    logic [15:0] entry_count_ff, trap_count_ff;
    logic apb_access;
    logic [31:0] rd_mux;
    logic rd_hit;
    logic [6:0] opc;
    shift_res_t shift_res;
    microword_t uword;

    assign opc = instr_i[15:9];

    // Signed shift over 32 bits; word mode puts the operand in the high half
    function automatic shift_res_t do_shift(input logic [15:0] hi, input logic [15:0] lo,
                                            input logic [5:0] cnt, input logic comb);
        logic [31:0] x;
        logic [32:0] tmp;
        logic [31:0] r;
        logic [5:0] n;
        shift_res_t res;
        x = comb ? {hi, lo} : {hi, 16'h0000};
        res = '0;
        if (cnt[5])
        begin
            n = 6'(-cnt);
            tmp = 33'($signed({x, 1'b0}) >>> n);
            r = tmp[32:1];
            res.cc.c = comb ? tmp[0] : tmp[16];
            res.cc.v = 1'b0;
        end
        else
        begin
            tmp = {1'b0, x} << cnt;
            r = tmp[31:0];
            res.cc.c = (cnt == 6'h00) ? 1'b0 : tmp[32];
            res.cc.v = (32'($signed(r) >>> cnt) != x);
        end
        res.high = r[31:16];
        res.low = comb ? r[15:0] : r[31:16];
        res.cc.n = r[31];
        res.cc.z = comb ? (r == 32'h0) : (r[31:16] == 16'h0);
        return res;
    endfunction

    assign shift_res = do_shift(source_field_reg_i, odd_partner_reg_i | 16'h0000,
                                holding_reg_o[5:0], is_comb_ff);

    // Flow sequencing
    always_comb
    begin
        nxt_state = state_ff;
        unique case (state_ff)
            ST_IDLE:
                if (option_enable_ff && store_select_bit_i)
                    nxt_state = ST_ENTRY;
            ST_ENTRY:
                nxt_state = ST_SECOND;
            ST_SECOND:
                if (is_float_ff)
                    nxt_state = ST_STATUS;
                else if (!is_own_ff)
                    nxt_state = ST_VECTOR;
                else
                    nxt_state = ST_DEST;
            ST_DEST:
                if (dest_cnt_ff == 3'h0)
                    nxt_state = ST_SHIFT;
            ST_SHIFT:
                nxt_state = ST_STATUS;
            ST_STATUS:
                nxt_state = ST_CLEAN;
            ST_CLEAN:
                nxt_state = ST_IDLE;
            ST_VECTOR:
                nxt_state = ST_TRAPST;
            ST_TRAPST:
                nxt_state = ST_IDLE;
            default:
                nxt_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
            state_ff <= ST_IDLE;
        else
            state_ff <= nxt_state;
    end

    // Microword contents per flow word
    always_comb
    begin
        uword = '0;
        uword.ctl = {32'h0, state_ff};
        uword.opt_hi = {15'h0, state_ff};
        unique case (state_ff)
            ST_IDLE:
                uword.opt_hi = 24'h0;
            ST_ENTRY:
            begin
                uword.branch = `BR_CODE_DEST_MODE;
                uword.next_addr = `UADDR_OPTION_ENTRY;
            end
            ST_DEST:
                if (dest_cnt_ff == `DEST_TEST_LEAD)
                    uword.branch = `BR_CODE_OPCODE;
            ST_CLEAN:
            begin
                uword.opt_hi = 24'h0;
                uword.next_addr = `UADDR_SERVICE_RETURN;
            end
            ST_VECTOR:
                uword.next_addr = `UADDR_VECTOR_FORM;
            ST_TRAPST:
                uword.next_addr = `UADDR_ALT_TRAP;
            default:
                uword.branch = `BR_CODE_NONE;
        endcase
    end

    // Option store drives the shared microword bus only while selected
    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            micro_word_o <= 57'h0;
            option_word_o <= 24'h0;
            micro_pointer_o <= 10'h0;
            option_branch_code_o <= 6'h00;
        end
        else
        begin
            micro_word_o <= store_select_bit_i ? uword[56:0] : 57'h0;
            option_word_o <= uword.opt_hi;
            micro_pointer_o <= uword.next_addr;
            option_branch_code_o <= uword.branch;
        end
    end

    // Select bit clocking: dispatch entry sets, the status and vector words clear it
    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            store_select_clk_o <= 1'b0;
            store_select_d_o <= 1'b0;
        end
        else if (dispatch_test_i && timing_pulse_i && option_enable_ff)
        begin
            store_select_clk_o <= 1'b1;
            store_select_d_o <= reserved_instr_flag_i & option_select_copy_ff;
        end
        else if (state_ff == ST_STATUS || state_ff == ST_VECTOR)
        begin
            store_select_clk_o <= 1'b1;
            store_select_d_o <= 1'b0;
        end
        else
        begin
            store_select_clk_o <= 1'b0;
            store_select_d_o <= 1'b0;
        end
    end

    // The copy follows the enable so a missing option never answers dispatch
    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            option_select_copy_ff <= 1'b0;
            option_store_en_o <= 1'b0;
            base_store_dis_o <= 1'b0;
        end
        else
        begin
            option_select_copy_ff <= option_enable_ff;
            option_store_en_o <= store_select_bit_i;
            base_store_dis_o <= store_select_bit_i;
        end
    end

    // Instruction re-decode in the entry word
    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            is_own_ff <= 1'b0;
            is_float_ff <= 1'b0;
            is_comb_ff <= 1'b0;
            dest_mode_ff <= 3'h0;
            trap_flag_clr_o <= 1'b0;
        end
        else
        begin
            trap_flag_clr_o <= 1'b0;
            if (state_ff == ST_ENTRY)
            begin
                is_float_ff <= (instr_i[15:5] == `OPC_FLOAT_GROUP);
                is_own_ff <= ((opc >= `OPC_OWN_LOW) && (opc <= `OPC_OWN_HIGH))
                    || (instr_i[15:5] == `OPC_FLOAT_GROUP);
                is_comb_ff <= (opc == `OPC_ARITH_SHIFT_COMB);
                dest_mode_ff <= instr_i[5:3];
                trap_flag_clr_o <= ((opc >= `OPC_OWN_LOW) && (opc <= `OPC_OWN_HIGH))
                    || (instr_i[15:5] == `OPC_FLOAT_GROUP);
            end
        end
    end

    // Destination path length grows with mode up to mode 5; the opcode test sits two words early
    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
            dest_cnt_ff <= 3'h0;
        else if (state_ff == ST_SECOND)
            dest_cnt_ff <= (dest_mode_ff == 3'h0) ? `DEST_TEST_LEAD
                : ((dest_mode_ff > 3'h5) ? 3'h7 : dest_mode_ff + `DEST_TEST_LEAD);
        else if (state_ff == ST_DEST && dest_cnt_ff != 3'h0)
            dest_cnt_ff <= dest_cnt_ff - 3'h1;
    end

    // Datapath copies: operand capture, shift results, trap vector
    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            destination_field_reg_o <= 16'h0;
            holding_reg_o <= 16'h0;
            b_reg_o <= 16'h0;
            source_field_wr_o <= 16'h0;
            odd_partner_wr_o <= 16'h0;
            odd_partner_we_o <= 1'b0;
            vector_scratch_o <= 16'h0;
            trap_vector_o <= 16'h0;
            cc_ff <= '0;
        end
        else
        begin
            odd_partner_we_o <= 1'b0;
            unique case (state_ff)
                ST_DEST:
                    if (dest_cnt_ff == 3'h0)
                    begin
                        // Register mode needs no bus cycle
                        destination_field_reg_o <= (dest_mode_ff == 3'h0) ? dest_reg_i
                            : bus_data_i;
                        holding_reg_o <= (dest_mode_ff == 3'h0) ? dest_reg_i
                            : bus_data_i;
                        b_reg_o <= (dest_mode_ff == 3'h0) ? dest_reg_i : bus_data_i;
                    end
                ST_SHIFT:
                begin
                    holding_reg_o <= shift_res.high;
                    b_reg_o <= shift_res.high;
                    source_field_wr_o <= shift_res.high;
                    odd_partner_wr_o <= shift_res.low;
                    odd_partner_we_o <= is_comb_ff;
                    cc_ff <= shift_res.cc;
                end
                ST_VECTOR:
                    trap_vector_o <= `TRAP_VECTOR_RSVD;
                ST_TRAPST:
                begin
                    vector_scratch_o <= special_trap_marker_i;
                    b_reg_o <= special_trap_marker_i;
                end
                default:
                    odd_partner_we_o <= 1'b0;
            endcase
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
            proc_status_cc_o <= 4'h0;
        else if (state_ff == ST_STATUS)
            proc_status_cc_o <= cc_ff;
    end

    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            entry_count_ff <= 16'h0;
            trap_count_ff <= 16'h0;
        end
        else
        begin
            if (state_ff == ST_ENTRY)
                entry_count_ff <= entry_count_ff + 16'h1;
            if (state_ff == ST_TRAPST)
                trap_count_ff <= trap_count_ff + 16'h1;
        end
    end

    // APB slave: one wait state so the read data comes from a flip-flop
    assign apb_access = psel_i && penable_i && !pready_o;

    always_comb
    begin
        rd_hit = 1'b1;
        rd_mux = 32'h0;
        unique case (paddr_i)
            `APB_OFF_CTRL:
                rd_mux = {31'h0, option_enable_ff};
            `APB_OFF_STATUS:
                rd_mux = {16'h0, cc_ff, 2'h0, option_select_copy_ff, state_ff};
            `APB_OFF_RESULT:
                rd_mux = {source_field_wr_o, odd_partner_wr_o};
            `APB_OFF_COUNT:
                rd_mux = {trap_count_ff, entry_count_ff};
            default:
                rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o <= 32'h0;
        end
        else
        begin
            pready_o <= apb_access;
            pslverr_o <= apb_access && !rd_hit;
            prdata_o <= (apb_access && !pwrite_i) ? rd_mux : 32'h0;
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
            option_enable_ff <= 1'(`CTRL_RESET);
        // Write lands on the completion edge, when the master sees pready high
        else if (psel_i && penable_i && pready_o && pwrite_i && paddr_i == `APB_OFF_CTRL)
            option_enable_ff <= pwdata_i[0];
    end

endmodule

//--- option_dispatch_properties.sv
/*
 Checker for the option dispatch block, bound to its top module.
 Assumes one clock domain and the hand-over timing of the outputs.
*/
`timescale 1ns/100ps
module option_dispatch_properties
(
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_i,
    // APB
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pready_o,
    input wire logic pslverr_o,
    // Hand-off
    input wire logic store_select_bit_i,
    input wire logic reserved_instr_flag_i,
    input wire logic store_select_clk_o,
    input wire logic store_select_d_o,
    input wire logic option_store_en_o,
    input wire logic base_store_dis_o,
    input wire logic trap_flag_clr_o,
    input wire logic [56:0] micro_word_o,
    input wire logic [23:0] option_word_o,
    input wire logic [9:0] micro_pointer_o,
    input wire logic [5:0] option_branch_code_o,
    input wire logic [15:0] trap_vector_o,
    input wire logic [15:0] vector_scratch_o,
    input wire logic [15:0] b_reg_o
);
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (rst_i);

    apb_answer_a: assert property (psel_i && penable_i && !pready_o |=> pready_o)
        else $error("access phase not answered next cycle");
    apb_error_a: assert property (pslverr_o |-> pready_o)
        else $error("error flag without ready");
    sel_data_a: assert property (store_select_clk_o && store_select_d_o
        |-> $past(reserved_instr_flag_i))
        else $error("select data set without reserved flag");
    store_swap_a: assert property (option_store_en_o == $past(store_select_bit_i)
        && base_store_dis_o == option_store_en_o)
        else $error("store enables do not follow select bit");
    word_gate_a: assert property (!option_store_en_o |-> micro_word_o == 57'h0)
        else $error("option drives microword while disabled");
    entry_code_a: assert property (micro_pointer_o == 10'h140
        |-> option_branch_code_o == 6'h0f)
        else $error("entry word lacks mode branch code");
    vector_exit_a: assert property (micro_pointer_o == 10'h1a0
        |-> trap_vector_o == 16'h0008 ##1 micro_pointer_o == 10'h007)
        else $error("vector word wrong or not followed by trap exit");
    marker_a: assert property (micro_pointer_o == 10'h007
        |-> vector_scratch_o == b_reg_o)
        else $error("scratch and B differ at trap exit");
    clean_exit_a: assert property (micro_pointer_o == 10'h00f
        |-> option_word_o == 24'h0 && $past(store_select_clk_o) && !$past(store_select_d_o))
        else $error("return without select clear or with stale option bits");
    trap_clr_a: assert property (trap_flag_clr_o
        |-> micro_pointer_o == 10'h140 || $past(micro_pointer_o) == 10'h140)
        else $error("trap flag cleared outside the entry word");
endmodule

//--- cpu_sequencer_model.sv
/*
 Behavioural model of the processor sequencer facing the option.
 Assumes the bench asks for one dispatch at a time through go_i.
*/
`timescale 1ns/100ps
module cpu_sequencer_model
(
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_i,
    // Bench control
    input wire logic go_i,
    input wire logic ext_i,
    // Option hand-off
    input wire logic store_select_clk_i,
    input wire logic store_select_d_i,
    output logic dispatch_test_o,
    output logic timing_pulse_o,
    output logic reserved_instr_flag_o,
    output logic store_select_bit_o,
    output logic [9:0] next_uaddr_o
);
    // Dispatch test and pulse coincide in the pc-increment word
    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            dispatch_test_o <= 1'b0;
            timing_pulse_o <= 1'b0;
        end
        else
        begin
            dispatch_test_o <= go_i;
            timing_pulse_o <= go_i;
        end
    end

    // Select bit takes whatever data the option clocks in, also a clear
    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
            store_select_bit_o <= 1'b0;
        else if (store_select_clk_i)
            store_select_bit_o <= store_select_d_i;
    end

    assign reserved_instr_flag_o = ext_i;
    // Without the select bit the dispatch lands on the base dispatch word
    assign next_uaddr_o = store_select_bit_o ? 10'h140 : 10'h040;
endmodule

//--- tb_option_microcode_dispatch.sv
/*
 Testbench: APB register checks and dispatch flows through the option.
 Assumes the sequencer model closes the select-bit loop.
*/
`timescale 1ns/100ps
module tb_option_microcode_dispatch;
    logic sys_clk_i, rst_i, psel_i, penable_i, pwrite_i, go, ext;
    logic [11:0] paddr_i;
    logic [31:0] pwdata_i, q;
    logic [15:0] instr_i, bus_data_i, dest_reg_i, source_field_reg_i;
    logic [15:0] odd_partner_reg_i, special_trap_marker_i;
    logic e, saw_e, saw_o, saw_c, saw_w;
    wire [31:0] prdata_o;
    wire pready_o, pslverr_o, dispatch_test_i, timing_pulse_i, reserved_instr_flag_i;
    wire store_select_bit_i, store_select_clk_o, store_select_d_o, option_store_en_o;
    wire base_store_dis_o, trap_flag_clr_o, odd_partner_we_o;
    wire [56:0] micro_word_o;
    wire [23:0] option_word_o;
    wire [9:0] micro_pointer_o, nua;
    wire [5:0] option_branch_code_o;
    wire [15:0] destination_field_reg_o, holding_reg_o, b_reg_o, source_field_wr_o;
    wire [15:0] odd_partner_wr_o, vector_scratch_o, trap_vector_o;
    wire [3:0] proc_status_cc_o;
    int miscompares, n_tests, cyc;

    option_microcode_dispatch i_option_microcode_dispatch (.sys_clk_i, .rst_i,
        .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o,
        .pslverr_o, .dispatch_test_i, .timing_pulse_i, .reserved_instr_flag_i,
        .store_select_bit_i, .instr_i, .store_select_clk_o, .store_select_d_o,
        .option_store_en_o, .base_store_dis_o, .trap_flag_clr_o, .micro_word_o,
        .option_word_o, .micro_pointer_o, .option_branch_code_o, .bus_data_i,
        .dest_reg_i, .source_field_reg_i, .odd_partner_reg_i, .special_trap_marker_i,
        .destination_field_reg_o, .holding_reg_o, .b_reg_o, .source_field_wr_o,
        .odd_partner_wr_o, .odd_partner_we_o, .vector_scratch_o, .trap_vector_o,
        .proc_status_cc_o);

    cpu_sequencer_model i_cpu_sequencer_model (.sys_clk_i, .rst_i, .go_i(go),
        .ext_i(ext), .store_select_clk_i(store_select_clk_o),
        .store_select_d_i(store_select_d_o), .dispatch_test_o(dispatch_test_i),
        .timing_pulse_o(timing_pulse_i), .reserved_instr_flag_o(reserved_instr_flag_i),
        .store_select_bit_o(store_select_bit_i), .next_uaddr_o(nua));

    initial
    begin
        sys_clk_i = 1'b0;
        forever #10 sys_clk_i = ~sys_clk_i;
    end

    task report_and_stop;
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // Ceiling well above the few hundred cycles the flows need
    always @(posedge sys_clk_i)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            miscompares++;
            report_and_stop();
        end
    end

    task chk(input string s, input logic [31:0] x, input logic [31:0] g);
        n_tests++;
        if (g !== x)
        begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", s, x, g);
        end
    endtask

    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge sys_clk_i);
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge sys_clk_i);
        penable_i <= 1'b1;
        // Only the bench timeout ends a hung access
        do
            @(posedge sys_clk_i);
        while (pready_o !== 1'b1);
        q = prdata_o;
        e = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask

    task rd(input logic [11:0] a, input logic [31:0] x, input string s);
        apb(1'b0, a, 32'h0);
        chk(s, x, q);
    endtask

    // Dispatch one instruction and watch the flow until the given exit word
    task run(input logic [15:0] ins, input logic x, input logic [9:0] last);
        int n;
        n = 0;
        saw_e = 1'b0;
        saw_o = 1'b0;
        saw_c = 1'b0;
        saw_w = 1'b0;
        @(posedge sys_clk_i);
        instr_i <= ins;
        ext <= x;
        go <= 1'b1;
        @(posedge sys_clk_i);
        go <= 1'b0;
        do
        begin
            @(negedge sys_clk_i);
            n++;
            saw_e |= option_branch_code_o === 6'h0f;
            saw_o |= option_branch_code_o === 6'h0e;
            saw_c |= trap_flag_clr_o === 1'b1;
            saw_w |= odd_partner_we_o === 1'b1;
        end
        while (micro_pointer_o !== last && n < 60);
        if (last != 10'h3ff)
            chk("flow_end", {22'h0, last}, {22'h0, micro_pointer_o});
        repeat (4) @(posedge sys_clk_i);
    endtask

    initial
    begin
        {rst_i, psel_i, penable_i, pwrite_i, go, ext} = 6'b100000;
        {paddr_i, pwdata_i, instr_i, bus_data_i, dest_reg_i} = '0;
        {source_field_reg_i, odd_partner_reg_i, special_trap_marker_i} = '0;
        repeat (5) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        rd(12'h000, 32'h1, "ctrl");
        rd(12'h004, 32'h201, "status");
        rd(12'h008, 32'h0, "result");
        rd(12'h00c, 32'h0, "count");
        apb(1'b1, 12'h004, 32'hffff);
        rd(12'h004, 32'h201, "status_ro");
        rd(12'h010, 32'h0, "unmapped");
        chk("unmapped_err", 32'h1, {31'h0, e});
        dest_reg_i <= 16'h0001;
        bus_data_i <= 16'h0002;
        source_field_reg_i <= 16'h0001;
        for (int m = 0; m < 8; m++)
        begin
            run({7'h3a, 3'd2, m[2:0], 3'd3}, 1'b1, 10'h00f);
            chk("ash_src", (m == 0) ? 32'h2 : 32'h4, {16'h0, source_field_wr_o});
            chk("ash_hold", (m == 0) ? 32'h2 : 32'h4, {16'h0, holding_reg_o});
            chk("dest_reg", (m == 0) ? 32'h1 : 32'h2, {16'h0, destination_field_reg_o});
            chk("br_codes", 32'h3, {30'h0, saw_e, saw_o});
            chk("own_clr", 32'h1, {31'h0, saw_c});
        end
        dest_reg_i <= 16'h003e;
        source_field_reg_i <= 16'h8004;
        run(16'h7483, 1'b1, 10'h00f);
        chk("ash_right", 32'he001, {16'h0, b_reg_o});
        chk("ash_cc", 32'h8, {28'h0, proc_status_cc_o});
        bus_data_i <= 16'h0004;
        source_field_reg_i <= 16'h1234;
        odd_partner_reg_i <= 16'h5678;
        run(16'h768b, 1'b1, 10'h00f);
        chk("arith_shift_combined_high", 32'h2345, {16'h0, source_field_wr_o});
        chk("arith_shift_combined_low", 32'h6780, {16'h0, odd_partner_wr_o});
        chk("arith_shift_combined_we", 32'h1, {31'h0, saw_w});
        chk("arith_shift_combined_cc", 32'h3, {28'h0, proc_status_cc_o});
        rd(12'h008, 32'h2345_6780, "result_reg");
        special_trap_marker_i <= 16'h1c3d;
        run(16'h0007, 1'b1, 10'h007);
        chk("scratch", 32'h1c3d, {16'h0, vector_scratch_o});
        chk("b_marker", 32'h1c3d, {16'h0, b_reg_o});
        chk("vector", 32'h8, {16'h0, trap_vector_o});
        chk("rsvd_clr", 32'h0, {31'h0, saw_c});
        chk("back_base", 32'h040, {22'h0, nua});
        run(16'h7a80, 1'b1, 10'h00f);
        chk("float_path", 32'h2, {30'h0, saw_e, saw_o});
        chk("float_clr", 32'h1, {31'h0, saw_c});
        apb(1'b1, 12'h000, 32'h0);
        rd(12'h000, 32'h0, "ctrl_off");
        run(16'h7483, 1'b1, 10'h3ff);
        chk("no_option", 32'h040, {22'h0, nua});
        chk("no_entry", 32'h0, {31'h0, saw_e});
        apb(1'b1, 12'h000, 32'h1);
        run(16'h7483, 1'b1, 10'h00f);
        chk("re_entry", 32'h1, {31'h0, saw_e});
        report_and_stop();
    end
endmodule

bind option_microcode_dispatch option_dispatch_properties i_option_dispatch_properties (
    .sys_clk_i, .rst_i, .psel_i, .penable_i, .pready_o, .pslverr_o,
    .store_select_bit_i, .reserved_instr_flag_i, .store_select_clk_o, .store_select_d_o,
    .option_store_en_o, .base_store_dis_o, .trap_flag_clr_o, .micro_word_o,
    .option_word_o, .micro_pointer_o, .option_branch_code_o, .trap_vector_o,
    .vector_scratch_o, .b_reg_o);
